// ===== dv/hall_trim_and_linearizer_tb_top.sv
// Self-checking bench for the trim and linearizer stage
`timescale 1ns/1ps
module hall_trim_and_linearizer_tb_top;
	logic               clk_in = 1'b0;
	logic               reset_in = 1'b1;
	logic               ce_in = 1'b1;
	logic               reg_wr_in = 1'b0;
	logic               reg_rd_in = 1'b0;
	logic               sample_valid_in = 1'b0;
	logic               result_valid_out;
	logic [4:0]         reg_addr_in = 5'h00;
	logic [25:0]        reg_wdata_in = 26'h0000000;
	logic [25:0]        reg_rdata_out;
	logic signed [15:0] sample_in = 16'h0000;
	logic signed [15:0] result_out;
	logic signed [7:0]  temp_in = 8'h19;
	int                 n_mismatch = 0;
	int                 checked = 0;

	htl_top DUT (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
		.sample_in(sample_in), .temp_in(temp_in),
		.result_valid_out(result_valid_out), .result_out(result_out));

	initial forever #4 clk_in = ~clk_in;

	task automatic stop_test;
		$display("Checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [25:0] e,
		input logic [25:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [25:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [25:0] e);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk("read data", e, reg_rdata_out);
	endtask : rd

	// One sample in, wait for its result under a bounded count
	task automatic smp(input logic signed [15:0] x,
		input logic signed [7:0] t, input logic signed [15:0] e);
		@(posedge clk_in);
		sample_valid_in <= 1'b1;
		sample_in <= x;
		temp_in <= t;
		@(posedge clk_in);
		sample_valid_in <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_in);
			if (result_valid_out === 1'b1) break;
		end
		chk("result valid", 26'h1, {25'h0, result_valid_out});
		chk("result", 26'(e), 26'(result_out));
	endtask : smp

	// Locations or entries 0 to 7 in lo, levels or entries 8 to 15 in hi
	task automatic fill(input logic [25:0] lo, input logic [25:0] hi,
		input logic [25:0] ctl);
		for (int a = 10; a < 18; a++) wr(5'(a), (a < 14) ? lo : hi);
		wr(5'h12, ctl);
	endtask : fill

	task automatic t_reset;
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		reg_rd_in <= 1'b1;
		reg_addr_in <= 5'h03;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk("gain reset", 26'h0000400, reg_rdata_out);
		rd(5'h04, 26'h0000000);
		rd(5'h08, 26'h0000000);
	endtask : t_reset

	task automatic t_regs;
		@(posedge clk_in);
		ce_in <= 1'b0;
		reg_wr_in <= 1'b1;
		reg_addr_in <= 5'h07;
		reg_wdata_in <= 26'h0000001;
		@(posedge clk_in);
		ce_in <= 1'b1;
		reg_wr_in <= 1'b0;
		rd(5'h07, 26'h0000000);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= 5'h12;
		reg_wdata_in <= 26'h2ABCDEF;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk("table control", 26'h2ABCDEF, reg_rdata_out);
		wr(5'h12, 26'h0000000);
		wr(5'h1F, 26'h0001234);
		rd(5'h1F, 26'h0000000);
	endtask : t_regs

	task automatic t_gain;
		smp(16'sd1000, 8'sd25, 16'sd1000);
		wr(5'h06, 26'h0000005);
		smp(16'sd1000, 8'sd25, 16'sd1005);
		wr(5'h03, 26'h0008400);
		smp(16'sd1000, 8'sd25, -16'sd995);
		wr(5'h03, 26'h0001400);
		smp(16'sd1000, 8'sd25, 16'sd2005);
		wr(5'h03, 26'h0000200);
		smp(16'sd1000, 8'sd25, 16'sd505);
		wr(5'h03, 26'h0000400);
		wr(5'h06, 26'h0000000);
	endtask : t_gain

	task automatic t_drift;
		wr(5'h04, 26'h0019019);
		wr(5'h05, 26'h00001F4);
		wr(5'h07, 26'h0002003);
		smp(16'sd1000, 8'sd35, 16'sd1076);
		smp(16'sd1000, 8'sd15, 16'sd940);
		wr(5'h04, 26'h0000000);
		wr(5'h05, 26'h0000000);
		wr(5'h07, 26'h0000000);
	endtask : t_drift

	task automatic t_lin;
		fill(26'h00C8064, 26'h00C8064, 26'h0002064);
		smp(16'sd1000, 8'sd25, 16'sd1400);
		wr(5'h12, 26'h2002064);
		smp(16'sd1000, 8'sd25, 16'sd1800);
		fill(26'h3F39F9C, 26'h3F39F9C, 26'h0003F9C);
		smp(16'sd1000, 8'sd25, 16'sd600);
		fill(26'h00C8000, 26'h00C8000, 26'h0002000);
		smp(16'sd2048, 8'sd25, 16'sd2248);
		fill(26'h1FFEFFF, 26'h1FFEFFF, 26'h2002FFF);
		smp(16'sd32000, 8'sd25, 16'sd32767);
	endtask : t_lin

	task automatic t_bin;
		fill(26'h2001000, 26'h201500A, 26'h0006000);
		smp(16'sd1000, 8'sd25, 16'sd80);
		smp(-16'sd1000, 8'sd25, -16'sd32768);
		rd(5'h1F, 26'h0008000);
		wr(5'h12, 26'h0000000);
		smp(16'sd1000, 8'sd25, 16'sd1000);
		wr(5'h12, 26'h0010000);
		smp(16'sd1000, 8'sd25, -16'sd1000);
		wr(5'h12, 26'h0008000);
		smp(16'sd1000, 8'sd25, -16'sd1000);
		wr(5'h12, 26'h0018000);
		smp(16'sd1000, 8'sd25, 16'sd1000);
	endtask : t_bin

	initial begin
		t_reset();
		t_regs();
		t_gain();
		t_drift();
		t_lin();
		t_bin();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		stop_test();
	end
endmodule : hall_trim_and_linearizer_tb_top

bind htl_top htl_asserts u_chk (.clk_in(clk_in), .reset_in(reset_in),
	.ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .sample_valid_in(sample_valid_in),
	.result_valid_out(result_valid_out), .result_out(result_out));

// ===== dv/htl_asserts.sv
// Port checks for the trim and linearizer stage
`timescale 1ns/1ps
module htl_asserts (
	input wire logic               clk_in,
	input wire logic               reset_in,
	input wire logic               ce_in,
	input wire logic [4:0]         reg_addr_in,
	input wire logic [25:0]        reg_wdata_in,
	input wire logic               reg_wr_in,
	input wire logic               reg_rd_in,
	input wire logic [25:0]        reg_rdata_out,
	input wire logic               sample_valid_in,
	input wire logic               result_valid_out,
	input wire logic signed [15:0] result_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_run;
		ce_in [*5];
	endsequence
	chk_rdata_idle_zero: assert property (
		ce_in && !reg_rd_in |=> reg_rdata_out == 26'h0000000)
		else $error("read data not zero outside a read");
	chk_reset_clear: assert property (
		$fell(reset_in) |-> !result_valid_out && result_out == 16'h0000
		&& reg_rdata_out == 26'h0000000)
		else $error("outputs not cleared by reset");
	chk_valid_latency: assert property (
		sample_valid_in && ce_in ##1 s_run |=> result_valid_out)
		else $error("result valid missing six cycles after sample");
	chk_idle_latency: assert property (
		!sample_valid_in && ce_in ##1 s_run |=> !result_valid_out)
		else $error("result valid without a sample");
	chk_ce_freeze: assert property (
		!ce_in |=> $stable(result_out) && $stable(reg_rdata_out)
		&& $stable(result_valid_out))
		else $error("state moved while clock enable low");
	chk_unmapped_read: assert property (
		reg_rd_in && ce_in && reg_addr_in == 5'h08
		|=> reg_rdata_out == 26'h0000000)
		else $error("unmapped read not zero");
	chk_write_readback: assert property (
		(reg_wr_in && ce_in && reg_addr_in == 5'h12) ##1
		(reg_rd_in && ce_in && reg_addr_in == 5'h12)
		|=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("table control word did not read back");
	chk_reset_gain: assert property (
		$fell(reset_in) && ce_in && reg_rd_in && reg_addr_in == 5'h03
		|=> reg_rdata_out == 26'h0000400)
		else $error("gain word reset value wrong");
	chk_status_read: assert property (
		reg_rd_in && ce_in && reg_addr_in == 5'h1F
		|=> reg_rdata_out == {10'h000, $past(result_out)})
		else $error("status word differs from result");
	cover property (result_valid_out);
	cover property (reg_rd_in && reg_addr_in == 5'h1F);
	cover property (!ce_in && reg_wr_in);
endmodule : htl_asserts

// ===== hdl/htl_params.svh
// Register offsets, field positions, reset values and timing of the trim stage
`ifndef HTL_PARAMS_SVH
`define HTL_PARAMS_SVH

`define HTL_ADDR_W          5
`define HTL_DATA_W          26

`define HTL_OFS_GAIN        5'h03
`define HTL_OFS_LIN_DRIFT   5'h04
`define HTL_OFS_QUAD_DRIFT  5'h05
`define HTL_OFS_ZERO        5'h06
`define HTL_OFS_ZERO_DRIFT  5'h07
`define HTL_OFS_TABLE_FIRST 5'h0A
`define HTL_OFS_TABLE_LAST  5'h11
`define HTL_OFS_TABLE_CTRL  5'h12
`define HTL_OFS_STATUS      5'h1F

`define HTL_BIT_SIGN        15
`define HTL_BIT_LIN_EN      13
`define HTL_BIT_BIN_EN      14
`define HTL_BIT_OUT_INV     15
`define HTL_BIT_IN_INV      16
`define HTL_BIT_SCALAR      25

`define HTL_RST_GAIN        26'h0000400
`define HTL_RST_OTHER       26'h0000000

`define HTL_ROOM_TEMP_C     25
`define HTL_ENTRY_W         13
`define HTL_ENTRY_BIAS      17'h01000
`define HTL_SEG_FRAC_W      12
`define HTL_DRIFT_ONE       32'h00010000
`define HTL_QUAD_DIV        1000
`define HTL_PCT_DIV         25
`define HTL_GAIN_SHIFT      26
`define HTL_LATENCY         6

`endif

// ===== hdl/htl_pkg.sv
// Types shared by the trim and linearizer stage
package htl_pkg;

	typedef enum logic [1:0] {
		HTL_BYPASS,
		HTL_LIN,
		HTL_BIN
	} htl_mode_t;

	typedef logic signed [15:0] htl_sample_t;

	typedef logic [25:0] htl_word_t;

endpackage : htl_pkg

// ===== hdl/htl_top.sv
// Sensitivity and offset trim with drift compensation and linearization
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "htl_params.svh"

module htl_top #(
	parameter int TEMP_W = 8
) (
	input  wire logic                        clk_in,
	input  wire logic                        reset_in,
	input  wire logic                        ce_in,
	input  wire logic [`HTL_ADDR_W-1:0]      reg_addr_in,
	input  wire logic [`HTL_DATA_W-1:0]      reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	output logic      [`HTL_DATA_W-1:0]      reg_rdata_out,
	input  wire logic                        sample_valid_in,
	input  wire logic signed [15:0]          sample_in,
	input  wire logic signed [TEMP_W-1:0]    temp_in,
	output logic                             result_valid_out,
	output logic signed [15:0]               result_out
);

	localparam int NUM_ENTRIES = 17;
	localparam int NUM_BINS    = 8;
	localparam int DT_W        = TEMP_W + 1;

	logic      [`HTL_DATA_W-1:0] cfg_ff [0:31];
	logic      [`HTL_DATA_W-1:0] rdata_ff;
	logic      [`HTL_ENTRY_W-1:0] entry [0:NUM_ENTRIES-1];
	logic      [`HTL_LATENCY-1:0] valid_ff;

	logic signed [15:0]          s1_x_ff;
	logic signed [DT_W-1:0]      s1_dt_ff;
	logic signed [10:0]          s1_tc1_ff;
	logic signed [9:0]           s1_tc2_ff;
	logic signed [11:0]          s1_zdrift_ff;
	logic                        s1_neg_ff;
	logic      [2:0]             s1_coarse_ff;
	logic      [10:0]            s1_fine_ff;

	logic signed [31:0]          s2_prod_ff;
	logic signed [15:0]          s2_inner_ff;
	logic signed [DT_W-1:0]      s2_dt_ff;
	logic signed [11:0]          s2_zdrift_ff;

	logic signed [31:0]          s3_prod_ff;
	logic signed [31:0]          s3_drift_ff;
	logic signed [DT_W-1:0]      s3_dt_ff;
	logic signed [11:0]          s3_zdrift_ff;

	logic signed [15:0]          y1_ff;
	logic signed [DT_W-1:0]      s4_dt_ff;
	logic signed [11:0]          s4_zdrift_ff;

	logic signed [15:0]          y2_ff;
	logic signed [15:0]          result_ff;

	htl_pkg::htl_mode_t          mode;
	logic signed [15:0]          nxt_result;
	logic signed [DT_W-1:0]      nxt_dt;
	logic                        hot;
	logic signed [15:0]          lin_in_val;
	logic signed [15:0]          curve_val;
	logic signed [15:0]          gain_val;
	logic signed [31:0]          quad_val;
	logic signed [31:0]          term_val;
	logic signed [63:0]          full_val;
	logic signed [17:0]          zero_val;
	logic signed [63:0]          sum_val;

	function automatic logic is_mapped(input logic [`HTL_ADDR_W-1:0] a);
		is_mapped = (a >= `HTL_OFS_GAIN && a <= `HTL_OFS_ZERO_DRIFT) ||
			(a >= `HTL_OFS_TABLE_FIRST && a <= `HTL_OFS_TABLE_CTRL);
	endfunction : is_mapped

	function automatic logic signed [15:0] sat16(
		input logic signed [63:0] v
	);
		if (v > 64'sd32767) begin
			sat16 = 16'sh7FFF;
		end else if (v < -64'sd32768) begin
			sat16 = -16'sh8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// Biased 13-bit entry back to signed input or output units
	function automatic logic signed [17:0] unbias8(
		input logic [`HTL_ENTRY_W-1:0] e
	);
		logic signed [17:0] d;
		d = $signed({5'h00, e}) - $signed({1'b0, `HTL_ENTRY_BIAS});
		unbias8 = d <<< 3;
	endfunction : unbias8

	// Register file
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < 32; i++) begin
				cfg_ff[i] <= (i == 3) ? `HTL_RST_GAIN : `HTL_RST_OTHER;
			end
		end else if (ce_in && reg_wr_in && is_mapped(reg_addr_in)) begin
			cfg_ff[reg_addr_in] <= reg_wdata_in;
		end
	end

	// Read data stand for the single cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_ff <= `HTL_RST_OTHER;
		end else if (ce_in) begin
			if (reg_rd_in && is_mapped(reg_addr_in)) begin
				rdata_ff <= cfg_ff[reg_addr_in];
			end else if (reg_rd_in && reg_addr_in == `HTL_OFS_STATUS) begin
				rdata_ff <= {10'h000, result_ff};
			end else begin
				rdata_ff <= `HTL_RST_OTHER;
			end
		end
	end

	assign reg_rdata_out = rdata_ff;

	// Curve entries unpacked from the table words
	generate
		for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_entry
			localparam int WORD = 10 + g / 2;
			if (g % 2 == 0) begin : g_lo
				assign entry[g] = cfg_ff[WORD][12:0];
			end else begin : g_hi
				assign entry[g] = cfg_ff[WORD][25:13];
			end
		end
	endgenerate

	always_comb begin
		if (!cfg_ff[`HTL_OFS_TABLE_CTRL][`HTL_BIT_LIN_EN]) begin
			mode = htl_pkg::HTL_BYPASS;
		end else if (cfg_ff[`HTL_OFS_TABLE_CTRL][`HTL_BIT_BIN_EN]) begin
			mode = htl_pkg::HTL_BIN;
		end else begin
			mode = htl_pkg::HTL_LIN;
		end
	end

	assign nxt_dt = DT_W'(temp_in) - DT_W'(`HTL_ROOM_TEMP_C);
	assign hot    = (nxt_dt >= 0);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			valid_ff <= '0;
		end else if (ce_in) begin
			valid_ff <= {valid_ff[`HTL_LATENCY-2:0], sample_valid_in};
		end
	end

	// Stages 1, 5 and 6 read the configuration live, so a rewrite while
	// samples are in flight mixes old and new settings in up to five results
	// Stage 1: capture sample and pick the temperature region
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s1_x_ff      <= '0;
			s1_dt_ff     <= '0;
			s1_tc1_ff    <= '0;
			s1_tc2_ff    <= '0;
			s1_zdrift_ff <= '0;
			s1_neg_ff    <= 1'b0;
			s1_coarse_ff <= '0;
			s1_fine_ff   <= '0;
		end else if (ce_in) begin
			s1_x_ff      <= sample_in;
			s1_dt_ff     <= nxt_dt;
			s1_neg_ff    <= cfg_ff[`HTL_OFS_GAIN][`HTL_BIT_SIGN];
			s1_coarse_ff <= cfg_ff[`HTL_OFS_GAIN][14:12];
			s1_fine_ff   <= cfg_ff[`HTL_OFS_GAIN][10:0];
			if (hot) begin
				s1_tc1_ff    <= cfg_ff[`HTL_OFS_LIN_DRIFT][10:0];
				s1_tc2_ff    <= cfg_ff[`HTL_OFS_QUAD_DRIFT][9:0];
				s1_zdrift_ff <= cfg_ff[`HTL_OFS_ZERO_DRIFT][11:0];
			end else begin
				s1_tc1_ff    <= cfg_ff[`HTL_OFS_LIN_DRIFT][22:12];
				s1_tc2_ff    <= cfg_ff[`HTL_OFS_QUAD_DRIFT][21:12];
				s1_zdrift_ff <= cfg_ff[`HTL_OFS_ZERO_DRIFT][23:12];
			end
		end
	end

	// Stage 2 arithmetic: static gain and second-order drift share
	always_comb begin
		gain_val = $signed({2'b00,
			14'((s1_coarse_ff + 4'h1) * s1_fine_ff)});
		quad_val = 32'(s1_tc2_ff * s1_dt_ff) / `HTL_QUAD_DIV;
	end

	// Stage 2: static gain product and first drift term
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s2_prod_ff   <= '0;
			s2_inner_ff  <= '0;
			s2_dt_ff     <= '0;
			s2_zdrift_ff <= '0;
		end else if (ce_in) begin
			if (s1_neg_ff) begin
				s2_prod_ff <= 32'(s1_x_ff * -gain_val);
			end else begin
				s2_prod_ff <= 32'(s1_x_ff * gain_val);
			end
			s2_inner_ff  <= 16'(quad_val + 32'(s1_tc1_ff));
			s2_dt_ff     <= s1_dt_ff;
			s2_zdrift_ff <= s1_zdrift_ff;
		end
	end

	// Stage 3 arithmetic: drift term in units of 1/65536
	always_comb begin
		term_val = 32'(s2_inner_ff * s2_dt_ff) <<< 8;
	end

	// Stage 3: temperature gain factor, unity at 0x10000
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s3_prod_ff   <= '0;
			s3_drift_ff  <= `HTL_DRIFT_ONE;
			s3_dt_ff     <= '0;
			s3_zdrift_ff <= '0;
		end else if (ce_in) begin
			s3_prod_ff   <= s2_prod_ff;
			s3_drift_ff  <= $signed(`HTL_DRIFT_ONE) + term_val / `HTL_PCT_DIV;
			s3_dt_ff     <= s2_dt_ff;
			s3_zdrift_ff <= s2_zdrift_ff;
		end
	end

	// Stage 4 arithmetic: full product before the unity shift
	always_comb begin
		full_val = 64'(s3_prod_ff) * 64'(s3_drift_ff);
	end

	// Stage 4: gain trimmed result
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			y1_ff        <= '0;
			s4_dt_ff     <= '0;
			s4_zdrift_ff <= '0;
		end else if (ce_in) begin
			y1_ff        <= sat16(full_val >>> `HTL_GAIN_SHIFT);
			s4_dt_ff     <= s3_dt_ff;
			s4_zdrift_ff <= s3_zdrift_ff;
		end
	end

	// Stage 5 arithmetic: zero adjust and zero drift
	always_comb begin
		zero_val = cfg_ff[`HTL_OFS_ZERO][17:0];
		sum_val  = 64'(y1_ff) + 64'(zero_val) +
			64'(s4_zdrift_ff * s4_dt_ff);
	end

	// Stage 5: offset trimmed result
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			y2_ff <= '0;
		end else if (ce_in) begin
			y2_ff <= sat16(sum_val);
		end
	end

	// Linearizer input, optionally negated with saturation
	always_comb begin
		if (cfg_ff[`HTL_OFS_TABLE_CTRL][`HTL_BIT_IN_INV]) begin
			lin_in_val = sat16(-64'(y2_ff));
		end else begin
			lin_in_val = y2_ff;
		end
	end

	// Stage 6: curve evaluation
	always_comb begin
		logic      [15:0]   span;
		logic      [3:0]    seg;
		logic      [11:0]   frac;
		logic signed [17:0] ka;
		logic signed [17:0] kb;
		logic signed [31:0] slope;
		logic signed [63:0] acc;
		logic               scale;
		span   = '0;
		seg    = '0;
		frac   = '0;
		ka     = '0;
		kb     = '0;
		slope  = '0;
		acc    = '0;
		scale  = cfg_ff[`HTL_OFS_TABLE_CTRL][`HTL_BIT_SCALAR];
		case (mode)
			htl_pkg::HTL_LIN: begin
				span = {~lin_in_val[15], lin_in_val[14:0]};
				seg  = span[15:12];
				frac = span[`HTL_SEG_FRAC_W-1:0];
				ka   = 18'($signed(entry[seg]) <<< 2);
				kb   = 18'($signed(entry[5'(seg) + 5'h01]) <<< 2);
				if (scale) begin
					ka = ka <<< 1;
					kb = kb <<< 1;
				end
				slope = 32'((kb - ka) * $signed({1'b0, frac}));
				acc   = 64'(lin_in_val) + 64'(ka) +
					64'(slope >>> `HTL_SEG_FRAC_W);
				curve_val = sat16(acc);
			end
			htl_pkg::HTL_BIN: begin
				// Below the first location the output sits at negative full scale
				acc = -64'sd32768;
				for (int b = 0; b < NUM_BINS; b++) begin
					if (18'(lin_in_val) >= unbias8(entry[b])) begin
						acc = 64'(unbias8(entry[b + NUM_BINS]));
					end
				end
				if (scale) begin
					acc = acc <<< 1;
				end
				curve_val = sat16(acc);
			end
			htl_pkg::HTL_BYPASS: begin
				curve_val = lin_in_val;
			end
			default: begin
				curve_val = lin_in_val;
			end
		endcase
	end

	// Linearizer output, optionally negated with saturation
	always_comb begin
		if (cfg_ff[`HTL_OFS_TABLE_CTRL][`HTL_BIT_OUT_INV]) begin
			nxt_result = sat16(-64'(curve_val));
		end else begin
			nxt_result = curve_val;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			result_ff <= '0;
		end else if (ce_in) begin
			result_ff <= nxt_result;
		end
	end

	assign result_out       = result_ff;
	assign result_valid_out = valid_ff[`HTL_LATENCY-1];

endmodule : htl_top
